// ===== tb/asr_host_ctrl_properties.sv
// Pin-level checks on the SRAM host controller
`timescale 1ns/1ps
module asr_host_ctrl_properties
	import asr_pkg::*;
(
	// Clock, reset and user side
	input wire logic              clk_sys_i,
	input wire logic              arst_n_i,
	input wire logic              req_valid_i,
	input wire logic              req_ready_o,
	input wire logic              busy_o,
	input wire logic              ret_active_o,
	// SRAM pins
	input wire logic [ADDR_W-1:0] sram_addr_o,
	input wire logic              chip_select_active_low_o,
	input wire logic              chip_select_active_high_o,
	input wire logic              sram_write_n_o,
	input wire logic              sram_output_en_n_o,
	input wire logic              lower_lane_select_n_o,
	input wire logic              upper_lane_select_n_o,
	input wire logic              sram_word_mode_o,
	input wire logic [DATA_W-1:0] sram_dq_oe_o
);
	wire logic sel_on = !chip_select_active_low_o && chip_select_active_high_o;
	wire logic lane_on = !(lower_lane_select_n_o && upper_lane_select_n_o);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!arst_n_i);

	a_strobe_needs_select: assert property (
		!sram_write_n_o |-> sel_on && lane_on) else $error("strobe low without selects");
	a_strobe_width: assert property (
		$fell(sram_write_n_o) |=> !sram_write_n_o ##1 sram_write_n_o)
		else $error("strobe pulse not two cycles");
	a_setup_before_end: assert property (
		$rose(sram_write_n_o) |-> $past(sel_on, 3) && $past(lane_on, 3)
		&& $past(sram_addr_o, 3) == sram_addr_o) else $error("setup before end too short");
	a_float_first: assert property (
		$fell(sram_write_n_o) |-> sram_dq_oe_o[14:0] == 15'h0) else $error("data driven at strobe fall");
	a_data_overlap: assert property (
		$rose(sram_write_n_o) |-> $past(sram_dq_oe_o[14:0]) != 15'h0
		&& sram_dq_oe_o == $past(sram_dq_oe_o)) else $error("data missing at write end");
	a_drive_in_write: assert property (
		sram_dq_oe_o[14:0] != 15'h0 |-> sel_on && (!sram_write_n_o || !$past(sram_write_n_o)))
		else $error("data driven outside write");
	a_oe_held_high: assert property (
		sram_output_en_n_o) else $error("output enable not high");
	a_write_spacing: assert property (
		req_valid_i && req_ready_o |=> busy_o [*4] ##1 !busy_o) else $error("write cycle length wrong");
	a_byte_lsb_driven: assert property (
		!sram_word_mode_o && sel_on |-> sram_dq_oe_o[15]) else $error("extra address bit not driven");
	a_lane_ret_word: assert property (
		ret_active_o && sel_on |-> sram_word_mode_o && !lane_on && sram_write_n_o)
		else $error("lane retention outside word mode");
endmodule

// ===== tb/asr_host_ctrl_tb_top.sv
// Self-checking bench for the SRAM host controller
`timescale 1ns/1ps
module asr_host_ctrl_tb_top
	import asr_pkg::*;
;
	localparam int unsigned REC_N = 6;
	logic              clk_sys_i, arst_n_i, req_valid_i, byte_mode_i, ret_req_i;
	logic [ADDR_W:0]   req_addr_i;
	logic [DATA_W-1:0] req_data_i;
	logic [1:0]        req_lanes_i, ret_sel_i;
	logic              req_ready_o, ret_active_o, busy_o, cs_n, cs_h, we_n, oe_n, lb_n, ub_n, word;
	logic [ADDR_W-1:0] sram_addr_o;
	logic [DATA_W-1:0] sram_dq_o, sram_dq_oe_o;
	// Released bits show the inverse of the present value on sram_dq_o
	wire logic [DATA_W-1:0] dq_bus = (sram_dq_oe_o & sram_dq_o) | (~sram_dq_oe_o & ~sram_dq_o);
	int fails, n_compared;

	asr_host_ctrl #(.RECOVER_CYC(REC_N), .BSETUP_CYC(4), .BREC_CYC(4)) i_asr_host_ctrl (
		.clk_sys_i, .arst_n_i, .req_valid_i, .req_ready_o, .req_addr_i, .req_data_i,
		.req_lanes_i, .byte_mode_i, .ret_req_i, .ret_sel_i, .ret_active_o, .busy_o,
		.sram_addr_o, .chip_select_active_low_o(cs_n), .chip_select_active_high_o(cs_h),
		.sram_write_n_o(we_n), .sram_output_en_n_o(oe_n), .lower_lane_select_n_o(lb_n),
		.upper_lane_select_n_o(ub_n), .sram_word_mode_o(word), .sram_dq_o, .sram_dq_oe_o);
	asr_sram_model i_asr_sram_model (.addr_i(sram_addr_o), .chip_select_active_low_i(cs_n),
		.chip_select_active_high_i(cs_h), .write_n_i(we_n), .lower_lane_select_n_i(lb_n),
		.upper_lane_select_n_i(ub_n), .word_mode_i(word), .dq_i(dq_bus));

	initial clk_sys_i = 1'b0;
	always #25 clk_sys_i = ~clk_sys_i;

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Ready is combinational, so it is read mid-cycle and the request
	// stays up until the rising edge at which it was seen high
	task automatic wait_ready;
		int   n;
		logic hit;
		n = 0;
		hit = 1'b0;
		while (!hit) begin
			@(negedge clk_sys_i);
			hit = (req_ready_o === 1'b1);
			@(posedge clk_sys_i);
			n++;
			if (!hit && n > 60) begin
				fails++;
				$display("[FAIL] ready wait expected 1 seen 0");
				final_report();
			end
		end
	endtask
	task automatic do_write(input logic [ADDR_W:0] a, input logic [DATA_W-1:0] d,
		input logic [1:0] ln);
		req_addr_i <= a;
		req_data_i <= d;
		req_lanes_i <= ln;
		req_valid_i <= 1'b1;
		wait_ready();
		req_valid_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task automatic t_word_writes;
		do_write(20'h00001, 16'hA5C3, 2'h3);
		do_write(20'h00002, 16'h1234, 2'h1);
		do_write(20'h00002, 16'hABCD, 2'h2);
		req_lanes_i <= 2'h0;
		repeat (6) @(posedge clk_sys_i);
		#1;
		chk("no lanes ready", 1'b0, req_ready_o);
		chk("word both lanes", 16'hA5C3, i_asr_sram_model.mem[1]);
		chk("word single lanes", 16'hAB34, i_asr_sram_model.mem[2]);
		@(posedge clk_sys_i);
		req_lanes_i <= 2'h3;
	endtask
	task automatic t_ret(input logic [1:0] s, input logic ch);
		int n;
		ret_sel_i <= s;
		ret_req_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		#1;
		chk("ret active", 1'b1, ret_active_o);
		chk("ret high select", ch, cs_h);
		if (s == 2'h1 || ch) chk("ret low select", s == 2'h1, cs_n);
		if (s == 2'h2 && ch) chk("ret lanes", 2'h3, {ub_n, lb_n});
		chk("ret ready", 1'b0, req_ready_o);
		@(posedge clk_sys_i);
		ret_req_i <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			#1;
			n++;
		end while (req_ready_o !== 1'b1 && n < 100);
		chk("recovery wait", REC_N + 1, n);
		if (req_ready_o !== 1'b1) begin
			final_report();
		end
		@(posedge clk_sys_i);
	endtask
	task automatic t_byte;
		byte_mode_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		#1;
		chk("mode change deselect", 1'b0, cs_h);
		@(posedge clk_sys_i);
		do_write(20'h00006, 16'h0077, 2'h0);
		do_write(20'h00007, 16'h0088, 2'h0);
		repeat (6) @(posedge clk_sys_i);
		#1;
		chk("byte mode pin", 1'b0, word);
		chk("byte lanes", 16'h8877, i_asr_sram_model.mem[3]);
		@(posedge clk_sys_i);
		t_ret(2'h2, 1'b0);
		byte_mode_i <= 1'b0;
		@(posedge clk_sys_i);
		do_write(20'h00005, 16'h5AA5, 2'h3);
		repeat (6) @(posedge clk_sys_i);
		#1;
		chk("word after byte", 16'h5AA5, i_asr_sram_model.mem[5]);
	endtask

	initial begin
		{arst_n_i, req_valid_i, byte_mode_i, ret_req_i, ret_sel_i} = '0;
		req_addr_i = '0;
		req_data_i = '0;
		req_lanes_i = 2'h3;
		repeat (10) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		#1;
		chk("idle selects", 4'hF, {cs_n, cs_h, we_n, oe_n});
		chk("idle ready", 3'h6, {req_ready_o, word, busy_o});
		@(posedge clk_sys_i);
		t_word_writes();
		t_ret(2'h1, 1'b1);
		t_ret(2'h2, 1'b1);
		t_ret(2'h0, 1'b0);
		t_byte();
		final_report();
	end
endmodule

bind asr_host_ctrl asr_host_ctrl_properties i_asr_host_ctrl_properties (
	.clk_sys_i, .arst_n_i, .req_valid_i, .req_ready_o, .busy_o, .ret_active_o,
	.sram_addr_o, .chip_select_active_low_o, .chip_select_active_high_o, .sram_write_n_o,
	.sram_output_en_n_o, .lower_lane_select_n_o, .upper_lane_select_n_o, .sram_word_mode_o,
	.sram_dq_oe_o);

// ===== tb/asr_sram_model.sv
// Behavioural SRAM that stores what the host writes
`timescale 1ns/1ps
module asr_sram_model
	import asr_pkg::*;
(
	// Device pins
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic              chip_select_active_low_i,
	input wire logic              chip_select_active_high_i,
	input wire logic              write_n_i,
	input wire logic              lower_lane_select_n_i,
	input wire logic              upper_lane_select_n_i,
	input wire logic              word_mode_i,
	input wire logic [DATA_W-1:0] dq_i
);
	logic [DATA_W-1:0] mem [0:15];
	logic              armed;
	logic              wr_act;
	// store window is the overlap, gated by the high select
	assign wr_act = !chip_select_active_low_i && chip_select_active_high_i && !write_n_i
		&& (!word_mode_i || !(lower_lane_select_n_i && upper_lane_select_n_i));
	// output enable stays high, so the model never drives the bus
	initial begin
		armed = 1'b0;
		for (int i = 0; i < 16; i++) begin
			mem[i] = 16'h0000;
		end
	end
	always @(posedge wr_act) begin
		armed = 1'b1;
	end
	// organisation, and extra address bit on the top data line
	always @(negedge wr_act) begin
		if (armed) begin
			if (word_mode_i) begin
				if (!lower_lane_select_n_i) begin
					mem[addr_i[3:0]][7:0] = dq_i[7:0];
				end
				if (!upper_lane_select_n_i) begin
					mem[addr_i[3:0]][15:8] = dq_i[15:8];
				end
			end else if (dq_i[15]) begin
				mem[addr_i[3:0]][15:8] = dq_i[7:0];
			end else begin
				mem[addr_i[3:0]][7:0] = dq_i[7:0];
			end
		end
		armed = 1'b0;
	end
endmodule

// ===== verilog/asr_host_ctrl.sv
// Host controller that writes an asynchronous SRAM and runs retention
// How it works
// - Write starts only when both selects, strobe and a lane are active.
// - Write ends when any select, strobe or lane goes inactive.
// - Host keeps data lines released until device output float time passed.
// - Write strobe held active at least 40 ns.
// - Address held valid at least 50 ns before write end.
// - Both chip selects active at least 50 ns before write end.
// - Intended lane selects active at least 50 ns before write end.
// - Write data valid at least 25 ns before write end.
// - Output enable held high during writes; tied-low output enable also works.
// - Retention by active-low select keeps active-high select at a solid level.
// - Lane-controlled retention allowed only in word mode.
// - Mode pin selects sixteen-bit word or eight-bit byte organisation.
// - Byte mode carries extra low address bit on top data line.
`timescale 1ns/1ps
module asr_host_ctrl
	import asr_pkg::*;
#(
	parameter int unsigned RECOVER_CYC = R_CYC,
	parameter int unsigned BSETUP_CYC  = BS_CYC,
	parameter int unsigned BREC_CYC    = BR_CYC
)
(
	// Clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              arst_n_i,
	// Write request from user logic
	input  wire logic              req_valid_i,
	output logic                   req_ready_o,
	input  wire logic [ADDR_W:0]   req_addr_i,
	input  wire logic [DATA_W-1:0] req_data_i,
	input  wire logic [1:0]        req_lanes_i,
	// Mode and retention control
	input  wire logic              byte_mode_i,
	input  wire logic              ret_req_i,
	input  wire logic [1:0]        ret_sel_i,
	output logic                   ret_active_o,
	output logic                   busy_o,
	// SRAM pins
	output logic [ADDR_W-1:0]      sram_addr_o,
	output logic                   chip_select_active_low_o,
	output logic                   chip_select_active_high_o,
	output logic                   sram_write_n_o,
	output logic                   sram_output_en_n_o,
	output logic                   lower_lane_select_n_o,
	output logic                   upper_lane_select_n_o,
	output logic                   sram_word_mode_o,
	output logic [DATA_W-1:0]      sram_dq_o,
	output logic [DATA_W-1:0]      sram_dq_oe_o
);

	// ----------------------------------------------------------------
	// Decoding helpers
	// ----------------------------------------------------------------
	// Lanes to strobe: byte mode always strobes both lane pins
	function automatic logic [1:0] lane_sel(input logic bm, input logic [1:0] ln);
		return bm ? 2'h3 : ln;
	endfunction

	// Data lines to drive in the data phase
	function automatic logic [DATA_W-1:0] data_mask(input logic bm, input logic [1:0] ln);
		logic [DATA_W-1:0] m;
		m = '0;
		if (bm) begin
			m[7:0] = 8'hFF;
		end else begin
			m[7:0]  = {8{ln[0]}};
			m[15:8] = {8{ln[1]}};
		end
		return m;
	endfunction

	// ----------------------------------------------------------------
	// State and pin registers
	// ----------------------------------------------------------------
	asr_state_t         state_ff;
	asr_state_t         nxt_state;
	logic               mode_ff;
	logic               nxt_mode;
	logic [1:0]         ret_how_ff;
	logic [1:0]         nxt_ret_how;
	logic [ADDR_W:0]    addr_ff;
	logic [ADDR_W:0]    nxt_addr;
	logic [DATA_W-1:0]  data_ff;
	logic [DATA_W-1:0]  nxt_data;
	logic [1:0]         lanes_ff;
	logic [1:0]         nxt_lanes;
	logic [ADDR_W-1:0]  pin_addr_ff;
	logic [ADDR_W-1:0]  nxt_pin_addr;
	logic               cs_n_ff;
	logic               nxt_cs_n;
	logic               cs_ff;
	logic               nxt_cs;
	logic               we_n_ff;
	logic               nxt_we_n;
	logic [1:0]         lane_n_ff;
	logic [1:0]         nxt_lane_n;
	logic [DATA_W-1:0]  dq_ff;
	logic [DATA_W-1:0]  nxt_dq;
	logic [DATA_W-1:0]  dq_oe_ff;
	logic [DATA_W-1:0]  nxt_dq_oe;
	logic               tmr_load;
	logic [CNT_W-1:0]   tmr_val;
	logic               tmr_done;
	logic               accept;
	logic               lanes_ok;

	asr_timer u_timer (
		.clk_sys_i  (clk_sys_i),
		.arst_n_i   (arst_n_i),
		.load_i     (tmr_load),
		.load_val_i (tmr_val),
		.done_o     (tmr_done)
	);

	// ----------------------------------------------------------------
	// Request handshake
	// ----------------------------------------------------------------
	// Word writes with no lane would never start, so they are held off
	assign lanes_ok    = byte_mode_i || (req_lanes_i != 2'h0);
	assign req_ready_o = (state_ff == ST_IDLE) && !ret_req_i &&
		(byte_mode_i == mode_ff) && lanes_ok;
	assign accept      = req_valid_i && req_ready_o;

	// ----------------------------------------------------------------
	// Next state and pin values
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state    = state_ff;
		nxt_mode     = mode_ff;
		nxt_ret_how  = ret_how_ff;
		nxt_addr     = addr_ff;
		nxt_data     = data_ff;
		nxt_lanes    = lanes_ff;
		tmr_load     = 1'b0;
		tmr_val      = '0;
		case (state_ff)
			ST_IDLE: begin
				if (ret_req_i) begin
					nxt_state   = ST_RET;
					nxt_ret_how = ret_sel_i;
					// lane method only in word mode
					if (ret_sel_i == RET_BY_LANES && mode_ff) begin
						nxt_ret_how = RET_BY_CS_HIGH;
					end
				end else if (byte_mode_i != mode_ff) begin
					nxt_state = ST_MSETUP;
					tmr_load  = 1'b1;
					tmr_val   = CNT_W'(BSETUP_CYC - 1);
				end else if (accept) begin
					nxt_state = ST_SETUP;
					nxt_addr  = req_addr_i;
					nxt_data  = req_data_i;
					nxt_lanes = lane_sel(mode_ff, req_lanes_i);
				end
			end
			ST_SETUP: begin
				nxt_state = ST_FLOAT;
				tmr_load  = 1'b1;
				tmr_val   = CNT_W'(FLOAT_CYC - 1);
			end
			ST_FLOAT: begin
				if (tmr_done) begin
					nxt_state = ST_DATA;
					tmr_load  = 1'b1;
					tmr_val   = CNT_W'(DATA_CYC - 1);
				end
			end
			ST_DATA: begin
				if (tmr_done) begin
					nxt_state = ST_END;
				end
			end
			ST_END: begin
				nxt_state = ST_IDLE;
			end
			ST_RET: begin
				if (!ret_req_i) begin
					nxt_state = ST_REC;
					tmr_load  = 1'b1;
					tmr_val   = CNT_W'(RECOVER_CYC - 1);
				end
			end
			ST_REC: begin
				if (tmr_done) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_MSETUP: begin
				if (tmr_done) begin
					nxt_state = ST_MREC;
					nxt_mode  = byte_mode_i;
					tmr_load  = 1'b1;
					tmr_val   = CNT_W'(BREC_CYC - 1);
				end
			end
			ST_MREC: begin
				if (tmr_done) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// Pin levels follow the state being entered, so pins are registered
	always_comb begin
		nxt_cs_n     = 1'b1;
		nxt_cs       = 1'b1;
		nxt_we_n     = 1'b1;
		nxt_lane_n   = 2'h3;
		nxt_dq       = '0;
		nxt_dq_oe    = '0;
		// address moves only on accept or mode change, steady through write end
		// byte mode uses the upper address bits on the address pins
		nxt_pin_addr = mode_ff ? nxt_addr[ADDR_W:1] : nxt_addr[ADDR_W-1:0];
		case (nxt_state)
			ST_SETUP, ST_FLOAT, ST_DATA, ST_END: begin
				// selects held through the whole write
				nxt_cs_n   = 1'b0;
				nxt_cs     = 1'b1;
				// lanes asserted from setup to release
				nxt_lane_n = ~nxt_lanes;
				// extra low address bit rides on the top data line
				if (mode_ff) begin
					nxt_dq[DATA_W-1]    = nxt_addr[0];
					nxt_dq_oe[DATA_W-1] = 1'b1;
				end
			end
			ST_RET: begin
				case (nxt_ret_how)
					// active-high select kept at a solid high
					RET_BY_CS_LOW: begin
						nxt_cs_n = 1'b1;
						nxt_cs   = 1'b1;
					end
					// both lanes off, selects active, word mode only
					RET_BY_LANES: begin
						nxt_cs_n = 1'b0;
						nxt_cs   = 1'b1;
					end
					// other inputs gated, held at quiet levels
					default: begin
						nxt_cs_n = 1'b1;
						nxt_cs   = 1'b0;
					end
				endcase
			end
			ST_MSETUP, ST_MREC: begin
				// Device deselected while the organisation changes
				nxt_cs = 1'b0;
			end
			default: begin
				nxt_cs_n = 1'b1;
			end
		endcase
		// strobe low across float and data phases
		// strobe is the last condition to go active
		if (nxt_state == ST_FLOAT || nxt_state == ST_DATA) begin
			nxt_we_n = 1'b0;
		end
		// data driven only after the float delay and kept one cycle past end
		// data stands for the whole data phase before the strobe rises
		if (nxt_state == ST_DATA || nxt_state == ST_END) begin
			nxt_dq[7:0]  = nxt_data[7:0];
			nxt_dq_oe    = nxt_dq_oe | data_mask(mode_ff, nxt_lanes);
			if (!mode_ff) begin
				nxt_dq[15:8] = nxt_data[15:8];
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_ff    <= ST_IDLE;
			mode_ff     <= 1'b0;
			ret_how_ff  <= RET_BY_CS_HIGH;
			addr_ff     <= '0;
			data_ff     <= '0;
			lanes_ff    <= 2'h0;
			pin_addr_ff <= '0;
			cs_n_ff     <= 1'b1;
			cs_ff       <= 1'b0;
			we_n_ff     <= 1'b1;
			lane_n_ff   <= 2'h3;
			dq_ff       <= '0;
			dq_oe_ff    <= '0;
		end else begin
			state_ff    <= nxt_state;
			mode_ff     <= nxt_mode;
			ret_how_ff  <= nxt_ret_how;
			addr_ff     <= nxt_addr;
			data_ff     <= nxt_data;
			lanes_ff    <= nxt_lanes;
			pin_addr_ff <= nxt_pin_addr;
			cs_n_ff     <= nxt_cs_n;
			cs_ff       <= nxt_cs;
			we_n_ff     <= nxt_we_n;
			lane_n_ff   <= nxt_lane_n;
			dq_ff       <= nxt_dq;
			dq_oe_ff    <= nxt_dq_oe;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// all four store conditions overlap only in float and data phases
	// strobe rise in the end phase closes the write first
	assign sram_addr_o               = pin_addr_ff;
	assign chip_select_active_low_o  = cs_n_ff;
	assign chip_select_active_high_o = cs_ff;
	assign sram_write_n_o            = we_n_ff;
	assign lower_lane_select_n_o     = lane_n_ff[0];
	assign upper_lane_select_n_o     = lane_n_ff[1];
	// output enable never asserted by this write-only host
	assign sram_output_en_n_o        = 1'b1;
	assign sram_word_mode_o          = !mode_ff;
	assign sram_dq_o                 = dq_ff;
	assign sram_dq_oe_o              = dq_oe_ff;
	assign ret_active_o              = (state_ff == ST_RET);
	// a write occupies setup, float, data and end, above cycle time
	assign busy_o                    = (state_ff != ST_IDLE);

endmodule

// ===== verilog/asr_pkg.sv
// Shared constants and types for the asynchronous SRAM write host
package asr_pkg;

	// ----------------------------------------------------------------
	// Clock and widths
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned ADDR_W        = 19;
	localparam int unsigned DATA_W        = 16;
	localparam int unsigned CNT_W         = 17;

	// ----------------------------------------------------------------
	// Device timing, lower supply range figures cover both ranges
	// ----------------------------------------------------------------
	localparam int unsigned T_WC_NS  = 55;
	localparam int unsigned T_AW_NS  = 50;
	localparam int unsigned T_CW_NS  = 50;
	localparam int unsigned T_BW_NS  = 50;
	localparam int unsigned T_WP_NS  = 40;
	localparam int unsigned T_DW_NS  = 25;
	localparam int unsigned T_WHZ_NS = 20;
	localparam int unsigned T_R_MS   = 5;
	localparam int unsigned T_BS_MS  = 5;
	localparam int unsigned T_BR_MS  = 5;

	// Least time in ns to whole cycles, never below one
	function automatic int unsigned ceil_cyc(input int unsigned t_ns);
		int unsigned c;
		c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c == 0) ? 1 : c;
	endfunction

	localparam int unsigned WC_CYC    = ceil_cyc(T_WC_NS);
	localparam int unsigned WP_CYC    = ceil_cyc(T_WP_NS);
	localparam int unsigned DW_CYC    = ceil_cyc(T_DW_NS);
	localparam int unsigned FLOAT_CYC = ceil_cyc(T_WHZ_NS);
	localparam int unsigned SEL_CYC   = ceil_cyc((T_AW_NS > T_CW_NS) ?
		((T_AW_NS > T_BW_NS) ? T_AW_NS : T_BW_NS) :
		((T_CW_NS > T_BW_NS) ? T_CW_NS : T_BW_NS));
	// Data phase long enough for overlap, pulse width and select setup
	localparam int unsigned DATA_CYC_A = (WP_CYC > FLOAT_CYC) ? WP_CYC - FLOAT_CYC : 1;
	localparam int unsigned DATA_CYC_B = (SEL_CYC > FLOAT_CYC + 1) ? SEL_CYC - FLOAT_CYC - 1 : 1;
	localparam int unsigned DATA_CYC_C = (DATA_CYC_A > DATA_CYC_B) ? DATA_CYC_A : DATA_CYC_B;
	localparam int unsigned DATA_CYC   = (DATA_CYC_C > DW_CYC) ? DATA_CYC_C : DW_CYC;
	localparam int unsigned R_CYC      = ceil_cyc(T_R_MS * 1000000);
	localparam int unsigned BS_CYC     = ceil_cyc(T_BS_MS * 1000000);
	localparam int unsigned BR_CYC     = ceil_cyc(T_BR_MS * 1000000);

	// ----------------------------------------------------------------
	// Retention entry methods
	// ----------------------------------------------------------------
	localparam logic [1:0] RET_BY_CS_HIGH = 2'h0;
	localparam logic [1:0] RET_BY_CS_LOW  = 2'h1;
	localparam logic [1:0] RET_BY_LANES   = 2'h2;

	// ----------------------------------------------------------------
	// Controller states
	// ----------------------------------------------------------------
	typedef enum logic [8:0] {
		ST_IDLE   = 9'h001,
		ST_SETUP  = 9'h002,
		ST_FLOAT  = 9'h004,
		ST_DATA   = 9'h008,
		ST_END    = 9'h010,
		ST_RET    = 9'h020,
		ST_REC    = 9'h040,
		ST_MSETUP = 9'h080,
		ST_MREC   = 9'h100
	} asr_state_t;

endpackage

// ===== verilog/asr_timer.sv
// Down counter that times the float, data, recovery and mode-change phases
`timescale 1ns/1ps
module asr_timer
	import asr_pkg::*;
(
	// Clock and reset
	input  wire logic             clk_sys_i,
	input  wire logic             arst_n_i,
	// Load and status
	input  wire logic             load_i,
	input  wire logic [CNT_W-1:0] load_val_i,
	output logic                  done_o
);

	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (load_i) begin
			nxt_cnt = load_val_i;
		end else if (cnt_ff != '0) begin
			nxt_cnt = cnt_ff - CNT_W'(1);
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// Phase of N cycles is loaded with N-1
	assign done_o = (cnt_ff == '0);

endmodule
